// ==== hdl/imb_exec.sv ====
// imb_exec: executes move, increment, increment-skip and unconditional jump
// assumes the fetch path feeds one word per cycle with instr_valid and that
// the file register read data for the word's address arrives combinationally.
`timescale 1ns/100ps
`default_nettype none
module imb_exec
  import imb_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    instr_valid,
  input  wire logic [imb_pkg::IW-1:0]  instr,
  input  wire logic [imb_pkg::DW-1:0]  file_rdata,
  input  wire logic [imb_pkg::UPW-1:0] pc_upper_latch,
  output logic [imb_pkg::AW-1:0]       file_addr,
  output logic [imb_pkg::DW-1:0]       file_wdata,
  output logic                         file_we,
  output logic [imb_pkg::DW-1:0]       w_out,
  output logic                         zero_flag,
  output logic [imb_pkg::PW-1:0]       pc,
  output logic                         flush
);
  import imb_pkg::*;

  imb_alu_op_t       alu_op;
  logic              is_jump;
  logic              dest_file;
  logic [AW-1:0]     faddr;
  logic [KW-1:0]     jump_k;

  logic [DW-1:0]     w_r;
  logic              z_r;
  logic [PW-1:0]     pc_r;
  logic              flush_r;
  logic [AW-1:0]     addr_r;
  logic [DW-1:0]     wdata_r;
  logic              we_r;

  imb_decode u_dec (
    .instr     (instr),
    .alu_op    (alu_op),
    .is_jump   (is_jump),
    .dest_file (dest_file),
    .faddr     (faddr),
    .jump_k    (jump_k)
  );

  // an instruction executes only when valid and not the word being discarded
  wire           exec      = instr_valid && !flush_r;
  wire           do_move   = exec && (alu_op == IMB_MOVE);
  wire           do_inc    = exec && (alu_op == IMB_INC);
  wire           do_incsz  = exec && (alu_op == IMB_INCSZ);
  wire           do_jump   = exec && is_jump;
  wire           has_res   = do_move || do_inc || do_incsz;
  // 8-bit add drops the carry, so 0xff wraps to 0x00
  wire [DW-1:0]  inc_val   = file_rdata + ONE;
  wire [DW-1:0]  result    = do_move ? file_rdata : inc_val;
  wire           res_zero  = (result == ZERO);
  wire           skip      = do_incsz && res_zero;
  wire           z_upd     = do_move || do_inc;
  wire           to_file   = has_res && dest_file;
  wire           to_w      = has_res && !dest_file;
  // jump target: low bits from the word, top bits from the upper latch
  wire [PW-1:0]  jump_pc   = {pc_upper_latch[UPL_HI:UPL_LO], jump_k};
  wire [PW-1:0]  pc_nxt    = do_jump ? jump_pc :
                             instr_valid ? pc_r + PW'(1) : pc_r;
  wire [DW-1:0]  w_nxt     = to_w ? result : w_r;
  wire           z_nxt     = z_upd ? res_zero : z_r;

  // working register, zero flag and program counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_r  <= ZERO;
      z_r  <= 1'b0;
      pc_r <= PC_RST;
    end else begin
      w_r  <= w_nxt;
      z_r  <= z_nxt;
      pc_r <= pc_nxt;
    end
  end

  // discard flag: the following fetched word becomes a nop cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flush_r <= 1'b0;
    end else if (instr_valid) begin
      flush_r <= skip || do_jump;
    end
  end

  // registered file write port; write lands one cycle after execution
  // limitation: a word reading the address written by the word before it sees stale data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      we_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= ZERO;
    end else begin
      we_r    <= to_file;
      addr_r  <= faddr;
      wdata_r <= result;
    end
  end

  assign file_addr  = addr_r;
  assign file_wdata = wdata_r;
  assign file_we    = we_r;
  assign w_out      = w_r;
  assign zero_flag  = z_r;
  assign pc         = pc_r;
  assign flush      = flush_r;

  // increment-skip never touches the zero flag
  chk_skip_keeps_z: assert property (@(posedge clk) disable iff (!resetn)
    do_incsz |=> zero_flag == $past(zero_flag))
    else $error("increment-skip changed the zero flag");

  chk_skip_zero_nop: assert property (@(posedge clk) disable iff (!resetn)
    (do_incsz && file_rdata == 8'hff && instr_valid) |=> flush)
    else $error("zero increment-skip did not discard next word");

  chk_skip_nonzero: assert property (@(posedge clk) disable iff (!resetn)
    (do_incsz && file_rdata != 8'hff) |=> !flush)
    else $error("nonzero increment-skip discarded next word");

  chk_jump_target: assert property (@(posedge clk) disable iff (!resetn)
    do_jump |=> pc == {$past(pc_upper_latch[4:3]), $past(instr[10:0])})
    else $error("jump target wrong");

  chk_jump_two_cyc: assert property (@(posedge clk) disable iff (!resetn)
    do_jump |=> (flush and (instr_valid |=> !flush)))
    else $error("jump did not take exactly two cycles");

  chk_move_to_w: assert property (@(posedge clk) disable iff (!resetn)
    (do_move && !instr[7]) |=> w_out == $past(file_rdata) && !file_we)
    else $error("move to W failed");

  chk_move_zflag: assert property (@(posedge clk) disable iff (!resetn)
    (do_move && instr[7]) |=> zero_flag == ($past(file_rdata) == 8'h00) && file_we)
    else $error("move to file did not set zero flag or write back");

  chk_inc_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (do_inc && instr[7] && file_rdata == 8'hff) |=> file_we && file_wdata == 8'h00 && zero_flag)
    else $error("increment did not wrap with zero flag");

  chk_move_decode: assert property (@(posedge clk) disable iff (!resetn)
    (exec && instr[13:8] == 6'h08) |-> alu_op == IMB_MOVE)
    else $error("move pattern not decoded");

  // increment-skip to W: sum wraps, nothing goes to the file
  chk_skip_to_w: assert property (@(posedge clk) disable iff (!resetn)
    (do_incsz && !dest_file) |=> w_out == $past(file_rdata) + ONE && !file_we)
    else $error("increment-skip to W wrong");

  // increment-skip back to the file leaves the working register alone
  chk_skip_to_file: assert property (@(posedge clk) disable iff (!resetn)
    (do_incsz && dest_file) |=> file_we && file_wdata == $past(file_rdata) + ONE
      && file_addr == $past(faddr) && w_out == $past(w_out))
    else $error("increment-skip write-back wrong");

  // a jump moves the pc and raises the discard flag, never the working register, zero flag or file
  chk_jump_no_flags: assert property (@(posedge clk) disable iff (!resetn)
    do_jump |=> zero_flag == $past(zero_flag) && w_out == $past(w_out) && !file_we)
    else $error("jump changed state other than the pc");

  // plain increment to W: sum wraps and the zero flag follows it
  chk_inc_to_w: assert property (@(posedge clk) disable iff (!resetn)
    (do_inc && !dest_file) |=> w_out == $past(file_rdata) + ONE && !file_we
      && zero_flag == (w_out == ZERO))
    else $error("increment to W wrong");

  // plain increment back to the file, zero flag from the written value
  chk_inc_to_file: assert property (@(posedge clk) disable iff (!resetn)
    (do_inc && dest_file) |=> file_we && file_wdata == $past(file_rdata) + ONE
      && zero_flag == (file_wdata == ZERO) && w_out == $past(w_out))
    else $error("increment to file wrong");

  // move back to the file rewrites the same address with the same value
  chk_move_to_file: assert property (@(posedge clk) disable iff (!resetn)
    (do_move && dest_file) |=> file_wdata == $past(file_rdata)
      && file_addr == $past(faddr) && w_out == $past(w_out))
    else $error("move to file wrong");

  // single-cycle operations never discard the word after them
  chk_one_cycle_ops: assert property (@(posedge clk) disable iff (!resetn)
    (do_move || do_inc) |=> !flush)
    else $error("single-cycle operation discarded next word");

  // a discarded word is a nop that still advances the pc
  chk_discard_nop: assert property (@(posedge clk) disable iff (!resetn)
    (flush && instr_valid) |=> !flush && !file_we && w_out == $past(w_out)
      && zero_flag == $past(zero_flag) && pc == $past(pc) + PW'(1))
    else $error("discarded word was not a nop");

  // an empty fetch slot changes nothing and keeps a pending discard
  chk_idle_holds: assert property (@(posedge clk) disable iff (!resetn)
    !instr_valid |=> pc == $past(pc) && flush == $past(flush) && !file_we
      && w_out == $past(w_out))
    else $error("idle slot changed state");

  // every executed word but a jump steps the pc by one
  chk_pc_step: assert property (@(posedge clk) disable iff (!resetn)
    (exec && !is_jump) |=> pc == $past(pc) + PW'(1))
    else $error("pc did not step by one");

  // the discard only ever follows a jump or an increment-skip
  chk_flush_cause: assert property (@(posedge clk) disable iff (!resetn)
    $rose(flush) |-> $past(do_jump) || $past(do_incsz))
    else $error("discard raised without a jump or increment-skip");
endmodule
`default_nettype wire

// ==== inc/imb_pkg.sv ====
// imb_pkg: constants shared by the increment / move / jump execution block
// assumes a 14-bit instruction word, 8-bit data path and 13-bit program counter
`default_nettype none
package imb_pkg;
  localparam int IW          = 14;            // instruction word width
  localparam int DW          = 8;             // data width
  localparam int AW          = 7;             // file address width
  localparam int PW          = 13;            // program counter width
  localparam int KW          = 11;            // jump immediate width
  localparam int UPW         = 8;             // upper latch width
  // opcode fields
  localparam logic [5:0] OPC_MOVE  = 6'h08;   // 00 1000 dfff ffff
  localparam logic [5:0] OPC_INC   = 6'h0a;   // 00 1010 dfff ffff
  localparam logic [5:0] OPC_INCSZ = 6'h0f;   // 00 1111 dfff ffff
  localparam logic [2:0] OPC_JUMP  = 3'h5;    // 10 1kkk kkkk kkkk
  localparam int OPC_HI      = 13;            // top of the opcode field
  localparam int OPC6_LO     = 8;             // low end of the 6-bit opcode
  localparam int OPC3_LO     = 11;            // low end of the 3-bit opcode
  localparam int DEST_BIT    = 7;             // destination select bit
  localparam int UPL_HI      = 4;             // latch bits copied to pc top
  localparam int UPL_LO      = 3;
  localparam logic [IW-1:0] NOP_WORD = 14'h0000;
  localparam logic [PW-1:0] PC_RST   = 13'h0000;
  localparam logic [DW-1:0] ONE      = 8'h01;
  localparam logic [DW-1:0] ZERO     = 8'h00;
  typedef enum logic [1:0] {IMB_NONE, IMB_MOVE, IMB_INC, IMB_INCSZ} imb_alu_op_t;
endpackage
`default_nettype wire

// ==== hdl/imb_decode.sv ====
// imb_decode: combinational decode of one instruction word into an alu op
// assumes the word is already fetched and stable for the cycle
`timescale 1ns/100ps
`default_nettype none
module imb_decode
  import imb_pkg::*;
(
  input  wire logic [imb_pkg::IW-1:0] instr,
  output var imb_pkg::imb_alu_op_t    alu_op,
  output logic                        is_jump,
  output logic                        dest_file,
  output logic [imb_pkg::AW-1:0]      faddr,
  output logic [imb_pkg::KW-1:0]      jump_k
);
  wire [5:0] opc6;
  wire [2:0] opc3;
  // field extraction
  assign opc6      = instr[OPC_HI:OPC6_LO];
  assign opc3      = instr[OPC_HI:OPC3_LO];
  assign dest_file = instr[DEST_BIT];
  assign faddr     = instr[AW-1:0];
  assign jump_k    = instr[KW-1:0];
  assign is_jump   = (opc3 == OPC_JUMP);
  // opcode match; anything else is not this block's business
  assign alu_op = (opc6 == OPC_MOVE)  ? IMB_MOVE  :
                  (opc6 == OPC_INC)   ? IMB_INC   :
                  (opc6 == OPC_INCSZ) ? IMB_INCSZ : IMB_NONE;
endmodule
`default_nettype wire

// ==== sim/imb_file_model.sv ====
// imb_file_model: file register array on the far side of imb_exec
// assumes writes come as a one-cycle strobe with registered address and data
`timescale 1ns/100ps
`default_nettype none
module imb_file_model
  import imb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [imb_pkg::AW-1:0] raddr,
  input  wire logic [imb_pkg::AW-1:0] waddr,
  input  wire logic [imb_pkg::DW-1:0] wdata,
  input  wire logic                   we,
  output logic [imb_pkg::DW-1:0]      rdata
);
  logic [DW-1:0] mem [0:127];
  // read is combinational, the exec block samples it in the same cycle
  assign rdata = mem[raddr];
  // write lands on the edge after the strobe, so the next word sees it late
  always @(posedge clk) if (we) mem[waddr] <= wdata;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// tb: self-checking bench for imb_exec with a file register model
// assumes one word per cycle, outputs checked half a cycle after the taking edge
`timescale 1ns/100ps
`default_nettype none
module tb;
  import imb_pkg::*;
  typedef struct packed {logic [13:0] ins; logic [7:0] dat, res; logic zu, sk;} imb_row_t;
  logic clk, resetn, instr_valid, file_we, zero_flag, flush, ez;
  logic [IW-1:0] instr;
  logic [DW-1:0] file_rdata, file_wdata, w_out, ew, up;
  logic [AW-1:0] file_addr;
  logic [PW-1:0] pc, epc;
  int error_cnt = 0, comparisons = 0;
  imb_row_t rows [7] = '{
    '{14'h0821, 8'h5a, 8'h5a, 1'b1, 1'b0}, '{14'h08a2, 8'h00, 8'h00, 1'b1, 1'b0},
    '{14'h0a23, 8'hff, 8'h00, 1'b1, 1'b0}, '{14'h0aa4, 8'h7f, 8'h80, 1'b1, 1'b0},
    '{14'h0fa5, 8'hff, 8'h00, 1'b0, 1'b1}, '{14'h0f26, 8'h05, 8'h06, 1'b0, 1'b0},
    '{14'h0f27, 8'hff, 8'h00, 1'b0, 1'b1}};
  imb_exec u_imb_exec (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .pc_upper_latch(up), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .w_out(w_out), .zero_flag(zero_flag),
    .pc(pc), .flush(flush));
  imb_file_model u_imb_file_model (.clk(clk), .raddr(instr[6:0]), .waddr(file_addr),
    .wdata(file_wdata), .we(file_we), .rdata(file_rdata));
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // present a word at the falling edge, hold it over one taking edge
  task automatic step(logic [13:0] ins);
    instr = ins;
    @(negedge clk);
    epc++;
  endtask
  // plain increment of 0x10 that follows each case; gives w=0x31 when executed
  task automatic follow(logic sk);
    u_imb_file_model.mem[7'h10] = 8'h30;
    step(14'h0a10);
    if (!sk) begin
      ew = 8'h31;
      ez = 1'b0;
    end
    chk("w", 13'(ew), 13'(w_out));
    chk("pc", epc, pc);
    chk("fl", 13'h0, 13'(flush));
    chk("we", 13'h0, 13'(file_we));
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 2000);
    error_cnt++;
    end_sim();
  end
  initial begin
    resetn = 1'b0; instr_valid = 1'b0; instr = 14'h0; up = 8'h0;
    epc = 13'h0; ew = 8'h0; ez = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    instr_valid = 1'b1;
    foreach (rows[i]) begin
      u_imb_file_model.mem[rows[i].ins[6:0]] = rows[i].dat;
      step(rows[i].ins);
      if (!rows[i].ins[7]) ew = rows[i].res;
      if (rows[i].zu) ez = (rows[i].res == 8'h00);
      chk("w", 13'(ew), 13'(w_out));
      chk("z", 13'(ez), 13'(zero_flag));
      chk("we", 13'(rows[i].ins[7]), 13'(file_we));
      if (rows[i].ins[7]) chk("wd", 13'(rows[i].res), 13'(file_wdata));
      if (rows[i].ins[7]) chk("wa", 13'(rows[i].ins[6:0]), 13'(file_addr));
      chk("fl", 13'(rows[i].sk), 13'(flush));
      follow(rows[i].sk);
    end
    // jumps to both ends of the immediate range with latch bits 4:3 at 01 and at 10
    for (int j = 0; j < 2; j++) begin
      up = j ? 8'hf7 : 8'h08;
      step({3'h5, j ? 11'h7ff : 11'h000});
      epc = {up[4:3], j ? 11'h7ff : 11'h000};
      chk("pcj", epc, pc);
      chk("flj", 13'h1, 13'(flush));
      follow(1'b1);
    end
    // a fetch gap after a jump keeps the discard pending over the idle slot
    step({OPC_JUMP, 11'h2aa});
    epc = {up[UPL_HI:UPL_LO], 11'h2aa};
    instr_valid = 1'b0;
    @(negedge clk);
    chk("pcg", epc, pc);
    chk("flg", 13'h1, 13'(flush));
    instr_valid = 1'b1;
    follow(1'b1);
    follow(1'b0);
    // load zero flag, write strobe and discard with nonzero values first; w still holds 0x31 from the last follow
    step(14'h08a2);
    chk("z", 13'h1, 13'(zero_flag));
    step(14'h0fa3);
    // reset in mid-run clears everything
    resetn = 1'b0;
    @(negedge clk);
    chk("rpc", 13'h0, pc);
    chk("rw", 13'h0, 13'(w_out));
    chk("rz", 13'h0, 13'(zero_flag));
    chk("rfl", 13'h0, 13'(flush));
    chk("rwe", 13'h0, 13'(file_we));
    chk("rwa", 13'h0, 13'(file_addr));
    // the first word after release must execute, not be discarded
    resetn = 1'b1;
    epc = 13'h0;
    follow(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
